/* File: osc_ctrl.sv */
// What this block does
// - First sample on conversion-start rising edge
// - Remaining samples use internal sampling strobe
// - Busy lengthens with selected ratio
// - Busy falling edge loads output registers
// - Ratio pins latched at busy fall
// - Decode ratio select; 111 invalid
`timescale 1ns/1ps
`default_nettype none
module osc_ctrl
(
	input  wire logic                                              mclk_i,
	input  wire logic                                              reset_i,
	input  wire logic                                              conversion_start_first_group_i,
	input  wire logic                                              conversion_start_second_group_i,
	input  wire logic [osc_pkg::OS_W-1:0]                          oversample_ratio_select_i,
	input  wire logic [osc_pkg::NUM_CH*osc_pkg::SAMPLE_W-1:0]      adc_data_i,
	input  wire logic                                              rd_i,
	input  wire logic [osc_pkg::CH_W-1:0]                          rd_addr_i,
	output logic                                                   sample_o,
	output logic                                                   busy_o,
	output logic      [osc_pkg::SAMPLE_W-1:0]                      rd_data_o,
	output logic                                                   rd_valid_o
);
	osc_pkg::osc_regs_t q;                                       // Registered state
	osc_pkg::osc_regs_t d;                                       // Next state
	logic                                          start_lvl;    // Combined start level
	logic                                          start_rise;   // Start rising edge
	logic [osc_pkg::OS_W-1:0]                      os_eff;       // Decoded ratio exponent
	logic                                          conv_end;     // Last cycle of a conversion
	logic                                          last_smp;     // Final sample of the burst
	logic                                          mem_wr;       // Refresh of the result bank
	logic [osc_pkg::NUM_CH-1:0][osc_pkg::ACC_W-1:0]    sum;     // Running sums with new sample
	logic [osc_pkg::NUM_CH-1:0][osc_pkg::SAMPLE_W-1:0] avg;     // Averaged results

	// Both inputs are expected to move together, so either one starts a run
	assign start_lvl  = conversion_start_first_group_i | conversion_start_second_group_i;
	assign start_rise = start_lvl & ~q.start_prev;

	// Invalid code falls back to single sampling
	assign os_eff = (q.os == osc_pkg::OS_INVALID) ? osc_pkg::OS_NONE : q.os;

	// End of one conversion, and the final one of the burst
	assign conv_end = (q.st == osc_pkg::OSC_CONV)
		&& (q.cnt == osc_pkg::CNT_W'(osc_pkg::CONV_CYC - 1));
	assign last_smp = (q.smp == ((osc_pkg::SMP_W'(1) << q.run_os) - osc_pkg::SMP_W'(1)));

	// Per channel sum and average; power-of-two ratio makes the divide a shift
	genvar g;
	generate
		for (g = 0; g < osc_pkg::NUM_CH; g++)
		begin : g_ch
			logic signed [osc_pkg::ACC_W-1:0] sext;   // Sign-extended sample
			logic signed [osc_pkg::ACC_W-1:0] total;  // Sum including this sample
			assign sext  = osc_pkg::ACC_W'(signed'(adc_data_i[g*osc_pkg::SAMPLE_W +: osc_pkg::SAMPLE_W]));
			assign total = signed'(q.acc[g]) + sext;
			assign sum[g] = total;
			assign avg[g] = osc_pkg::SAMPLE_W'(total >>> q.run_os);
		end
	endgenerate

	// Sequencer: one strobe per sample, busy spans the whole burst
	always_comb
	begin
		d = q;
		d.start_prev = start_lvl;
		d.sample = 1'b0;
		mem_wr = 1'b0;
		case (q.st)
			osc_pkg::OSC_IDLE:
			begin
				// Only the external edge opens a burst
				if (start_rise)
				begin
					d.st = osc_pkg::OSC_CONV;
					d.sample = 1'b1;
					d.run_os = os_eff;
					d.cnt = '0;
					d.smp = '0;
					d.len = '0;
					d.acc = '0;
				end
			end
			osc_pkg::OSC_CONV:
			begin
				// Edges on the start pins are ignored while busy
				d.cnt = q.cnt + osc_pkg::CNT_W'(1);
				d.len = q.len + osc_pkg::LEN_W'(1);
				if (conv_end)
				begin
					for (int i = 0; i < osc_pkg::NUM_CH; i++)
					begin
						d.acc[i] = sum[i];
					end
					if (last_smp)
					begin
						// Busy drops next edge; bank and ratio update together
						d.st = osc_pkg::OSC_IDLE;
						mem_wr = 1'b1;
						d.os = oversample_ratio_select_i;
					end
					else
					begin
						// Internal strobe takes the next sample
						d.cnt = '0;
						d.smp = q.smp + osc_pkg::SMP_W'(1);
						d.sample = 1'b1;
					end
				end
			end
			default:
			begin
				d.st = osc_pkg::OSC_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			q <= '0;
			q.os <= osc_pkg::OS_RESET;
		end
		else
		begin
			q <= d;
		end
	end

	assign sample_o = q.sample;
	assign busy_o   = (q.st == osc_pkg::OSC_CONV);

	// Results stay readable during busy; refresh happens at busy fall
	osc_result_mem osc_result_mem_i
	(
		.mclk_i     (mclk_i),
		.reset_i    (reset_i),
		.wr_all_i   (mem_wr),
		.wr_data_i  (avg),
		.rd_i       (rd_i),
		.rd_addr_i  (rd_addr_i),
		.rd_data_o  (rd_data_o),
		.rd_valid_o (rd_valid_o)
	);

	// Checks
	property p_first_sample;
		@(posedge mclk_i) disable iff (reset_i)
		(start_rise && !busy_o) |=> (sample_o && busy_o);
	endproperty
	a_first_sample: assert property (p_first_sample)
		else $error("no sample on start edge");

	property p_internal_sample;
		@(posedge mclk_i) disable iff (reset_i)
		(conv_end && !last_smp) |=> (sample_o && busy_o && $changed(q.smp));
	endproperty
	a_internal_sample: assert property (p_internal_sample)
		else $error("internal sample missing");

	// The strobe is a single pulse, so the core never double-samples
	property p_sample_pulse;
		@(posedge mclk_i) disable iff (reset_i)
		sample_o |=> !sample_o;
	endproperty
	a_sample_pulse: assert property (p_sample_pulse)
		else $error("sampling strobe longer than one cycle");

	property p_busy_len;
		@(posedge mclk_i) disable iff (reset_i)
		mem_wr |-> (q.len == ((osc_pkg::LEN_W'(osc_pkg::CONV_CYC) << q.run_os)
			- osc_pkg::LEN_W'(1)));
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("busy length wrong for ratio");

	property p_load_at_fall;
		@(posedge mclk_i) disable iff (reset_i)
		(busy_o && (d.st == osc_pkg::OSC_IDLE)) |-> mem_wr ##1 !busy_o;
	endproperty
	a_load_at_fall: assert property (p_load_at_fall)
		else $error("load not at busy fall");

	property p_os_latch;
		@(posedge mclk_i) disable iff (reset_i)
		mem_wr |=> (q.os == $past(oversample_ratio_select_i)) && !busy_o;
	endproperty
	a_os_latch: assert property (p_os_latch)
		else $error("ratio not latched at busy fall");

	// A new run must use the code latched at the previous busy fall
	property p_apply_ratio;
		@(posedge mclk_i) disable iff (reset_i)
		(start_rise && !busy_o) |=> (q.run_os == $past(os_eff));
	endproperty
	a_apply_ratio: assert property (p_apply_ratio)
		else $error("run ratio not taken from latched code");

	property p_decode;
		@(posedge mclk_i) disable iff (reset_i)
		(q.os == osc_pkg::OS_INVALID) ? (os_eff == osc_pkg::OS_NONE) : (os_eff == q.os);
	endproperty
	a_decode: assert property (p_decode)
		else $error("ratio decode wrong");

	property p_busy_hold;
		@(posedge mclk_i) disable iff (reset_i)
		(start_rise && !busy_o) |=> busy_o [*8];
	endproperty
	a_busy_hold: assert property (p_busy_hold)
		else $error("busy dropped early");

	// Busy may only fall after the final conversion of the burst
	property p_busy_until_last;
		@(posedge mclk_i) disable iff (reset_i)
		(busy_o && !(conv_end && last_smp)) |=> busy_o;
	endproperty
	a_busy_until_last: assert property (p_busy_until_last)
		else $error("busy fell before last sample");

	property p_single_avg;
		@(posedge mclk_i) disable iff (reset_i)
		(mem_wr && q.run_os == osc_pkg::OS_NONE) |-> (avg[0] == adc_data_i[osc_pkg::SAMPLE_W-1:0]);
	endproperty
	a_single_avg: assert property (p_single_avg)
		else $error("single sample result wrong");
endmodule
`default_nettype wire

/* File: osc_pkg.sv */
`default_nettype none
package osc_pkg;
	// Channel count and result width of the converter core
	localparam int NUM_CH   = 8;
	localparam int SAMPLE_W = 14;
	localparam int CH_W     = 3;
	// Accumulator carries six guard bits, enough for 64 signed samples
	localparam int ACC_W    = SAMPLE_W + 6;
	// Ratio select field and its special codes
	localparam int OS_W = 3;
	localparam logic [2:0] OS_NONE    = 3'h0;
	localparam logic [2:0] OS_INVALID = 3'h7;
	localparam logic [2:0] OS_RESET   = 3'h0;
	// Sample counter wide enough for 64 samples per result
	localparam int SMP_W = 7;
	// Conversion time of one sample on all channels, and its cycle count
	localparam int CLK_PERIOD_NS = 40;
	localparam int T_CONV_NS     = 4000;
	localparam int CONV_CYC      = (T_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W         = 8;
	// Busy length counter, up to 64 conversions
	localparam int LEN_W = 14;

	// Controller states
	typedef enum logic [1:0] {
		OSC_IDLE,
		OSC_CONV
	} osc_state_t;

	// Whole state of the controller
	typedef struct packed {
		osc_state_t                          st;
		logic                                start_prev;
		logic [OS_W-1:0]                     os;
		logic [OS_W-1:0]                     run_os;
		logic [CNT_W-1:0]                    cnt;
		logic [SMP_W-1:0]                    smp;
		logic                                sample;
		logic [NUM_CH-1:0][ACC_W-1:0]        acc;
		logic [LEN_W-1:0]                    len;
	} osc_regs_t;

	// Whole state of the result bank
	typedef struct packed {
		logic [NUM_CH-1:0][SAMPLE_W-1:0]     mem;
		logic [SAMPLE_W-1:0]                 rd_data;
		logic                                rd_valid;
	} osc_mem_t;
endpackage
`default_nettype wire

/* File: osc_result_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module osc_result_mem
(
	input  wire logic                                                   mclk_i,
	input  wire logic                                                   reset_i,
	input  wire logic                                                   wr_all_i,
	input  wire logic [osc_pkg::NUM_CH-1:0][osc_pkg::SAMPLE_W-1:0]      wr_data_i,
	input  wire logic                                                   rd_i,
	input  wire logic [osc_pkg::CH_W-1:0]                               rd_addr_i,
	output logic      [osc_pkg::SAMPLE_W-1:0]                           rd_data_o,
	output logic                                                        rd_valid_o
);
	osc_pkg::osc_mem_t q;   // Registered state
	osc_pkg::osc_mem_t d;   // Next state

	// Bank refresh and registered read; a read in the refresh cycle sees old data
	always_comb
	begin
		d = q;
		d.rd_valid = rd_i;
		if (rd_i)
		begin
			d.rd_data = q.mem[rd_addr_i];
		end
		if (wr_all_i)
		begin
			d.mem = wr_data_i;
		end
	end

	// State register
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	assign rd_data_o  = q.rd_data;
	assign rd_valid_o = q.rd_valid;
endmodule
`default_nettype wire

/* File: osc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host side: start pins and the analog source behind the core
module osc_host_model
(
	input  wire logic                                          mclk_i,
	input  wire logic                                          reset_i,
	input  wire logic                                          go_i,
	input  wire logic                                          busy_i,
	input  wire logic                                          sample_i,
	output logic                                               start_a_o,
	output logic                                               start_b_o,
	output logic [osc_pkg::NUM_CH*osc_pkg::SAMPLE_W-1:0]       adc_data_o
);
	localparam int W = osc_pkg::SAMPLE_W;
	logic       go_q  = 1'b0; // One start level for both groups
	logic [6:0] cnt_q = 7'h0; // Samples taken so far in this run
	logic [6:0] k_q   = 7'h0; // Index of the sample on the lines
	// Both pins come from one flop, so they can never split
	assign start_a_o = go_q;
	assign start_b_o = go_q;
	// Sample count restarts whenever the converter is idle
	always_ff @(posedge mclk_i)
	begin
		go_q <= go_i & ~reset_i;
		if (reset_i || !busy_i)
			cnt_q <= 7'h0;
		else if (sample_i)
		begin
			k_q   <= cnt_q;
			cnt_q <= cnt_q + 7'h1;
		end
	end
	// Sample k of channel c is c*100-40+2k; its mean over N is exact
	always_comb
	begin
		for (int c = 0; c < osc_pkg::NUM_CH; c++)
			adc_data_o[c*W +: W] = W'(c * 100 - 40 + 2 * int'(k_q));
	end
endmodule
`default_nettype wire

/* File: osc_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module osc_ctrl_tb;
	logic        mclk_i  = 1'b0;
	logic        reset_i = 1'b1;
	logic        go      = 1'b0; // Start request to the host model
	logic [2:0]  os_sel  = 3'h0; // Ratio pins
	logic        rd      = 1'b0;
	logic [2:0]  rd_addr = 3'h0;
	logic        start_a;
	logic        start_b;
	logic        sample;
	logic        busy;
	logic        rd_valid;
	logic [osc_pkg::NUM_CH*osc_pkg::SAMPLE_W-1:0] adc_data;
	logic [osc_pkg::SAMPLE_W-1:0] rd_data;
	logic [osc_pkg::SAMPLE_W-1:0] last3 = '0; // Bank is cleared by reset
	logic [2:0]  codes [9] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0, 3'h0};
	int          errors      = 0;
	int          checks_done = 0;

	osc_host_model osc_host_model_i (.mclk_i(mclk_i), .reset_i(reset_i), .go_i(go),
		.busy_i(busy), .sample_i(sample), .start_a_o(start_a), .start_b_o(start_b),
		.adc_data_o(adc_data));
	osc_ctrl osc_ctrl_i (.mclk_i(mclk_i), .reset_i(reset_i),
		.conversion_start_first_group_i(start_a), .conversion_start_second_group_i(start_b),
		.oversample_ratio_select_i(os_sel), .adc_data_i(adc_data), .rd_i(rd),
		.rd_addr_i(rd_addr), .sample_o(sample), .busy_o(busy), .rd_data_o(rd_data),
		.rd_valid_o(rd_valid));

	// 25 MHz clock
	initial
	begin
		forever #20 mclk_i = ~mclk_i;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Code 000 and the invalid code both mean one sample
	function automatic int ratio(input logic [2:0] c);
		return (c == 3'h0 || c == 3'h7) ? 1 : 1 << c;
	endfunction

	function automatic logic [osc_pkg::SAMPLE_W-1:0] mean(input int ch, input int n);
		return osc_pkg::SAMPLE_W'(ch * 100 - 40 + n - 1);
	endfunction

	// One read, judged in the cycle after it is taken
	task automatic read_ch(input int ch, input logic [osc_pkg::SAMPLE_W-1:0] exp);
		rd      <= 1'b1;
		rd_addr <= 3'(ch);
		@(posedge mclk_i);
		rd <= 1'b0;
		@(posedge mclk_i);
		check("rd_valid", rd_valid, 1);
		check("rd_data", rd_data, exp);
		@(posedge mclk_i);
		check("rd_valid_drop", rd_valid, 0);
	endtask

	// One run at N samples, with a refused restart and a read inside busy
	task automatic run_ratio(input int n);
		int t;
		int len;
		int smp;
		go <= 1'b1;
		@(posedge mclk_i);
		go <= 1'b0;
		t = 0;
		while (busy !== 1'b1 && t < 8)
		begin
			@(posedge mclk_i);
			t++;
		end
		check("sample_first", sample, 1);
		len = 0;
		smp = 0;
		while (busy === 1'b1 && len < 7000)
		begin
			smp += (sample === 1'b1);
			len++;
			go      <= (len == 5);
			rd      <= (len == 10);
			rd_addr <= 3'h3;
			if (len == 12)
				check("rd_old", rd_data, last3);
			@(posedge mclk_i);
		end
		check("busy_len", len, n * osc_pkg::CONV_CYC);
		check("samples", smp, n);
		// Reads start after busy has fallen, never on that edge
		for (int ch = 0; ch < osc_pkg::NUM_CH; ch++)
			read_ch(ch, mean(ch, n));
		last3 = mean(3, n);
	endtask

	// Each run uses the code latched when the previous run ended
	initial
	begin
		int n_prev;
		n_prev = 1;
		repeat (12) @(posedge mclk_i);
		reset_i <= 1'b0;
		@(posedge mclk_i);
		foreach (codes[i])
		begin
			os_sel <= codes[i];
			run_ratio(n_prev);
			n_prev = ratio(codes[i]);
		end
		final_report();
	end

	// Runs take about 13000 cycles in all
	initial
	begin
		repeat (40000) @(posedge mclk_i);
		errors++;
		final_report();
	end
endmodule
`default_nettype wire
